// ---- core/ictp_core.sv ----
// Protection and mode control of an isolated CAN transceiver.
// Assumes digitised supply, thermal, short and bus-comparator pins; the
// analog stage turns the enables below into real line levels.
//
// Functional notes
// - A main-supply undervoltage puts the block in protected mode with bus and receive released.
// - A logic-supply undervoltage, when that supply is present, forces protected mode as well.
// - With all monitored supplies valid the block runs in normal mode, bus per input, receive per bus.
// - Over-temperature switches the bus driver off so the transmit input no longer reaches the bus.
// - In thermal shutdown the bus sits recessive while the receive path keeps working.
// - Thermal shutdown ends when the temperature falls to the lower recovery level.
// - After a current-limited short the driver resumes by itself once the short is gone.
// - A transmit input held dominant longer than the timeout disables the driver.
// - After a timeout the driver stays off until a rising edge on the transmit input or an entry into protected mode, which also clears the timeout.
// - In normal mode a low, not timed-out transmit input drives dominant outside thermal shutdown, otherwise recessive.
// - In normal mode receive is low while the bus is dominant and high otherwise.
`default_nettype none

`include "ictp_regs.svh"

module ictp_core #(
    parameter int          DTO_CYCLES   = `ICTP_DTO_CYCLES,
    parameter logic        HAS_LOGIC_SUPPLY = 1'b1
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_main_supply_ok,
    input  wire logic                   i_logic_supply_ok,
    input  wire logic                   i_temp_over_shutdown,
    input  wire logic                   i_temp_over_recovery,
    input  wire logic                   i_short_detect,
    input  wire logic                   i_txd,
    input  wire logic                   i_bus_dominant,
    output var  logic                   o_bus_drive_dominant,
    output var  logic                   o_bus_bias_en,
    output var  logic                   o_current_limit,
    output var  logic                   o_rxd,
    output var  logic                   o_rxd_oe,
    output var  ictp_pkg::ictp_status_t o_status
);

    localparam int CNT_W = $clog2(DTO_CYCLES + 1);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic main_ok;
    logic logic_ok;
    logic hot_shut;
    logic hot_rec;
    logic short_s;
    logic txd_s;
    logic bus_dom;

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_main (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_main_supply_ok),
        .o_level(main_ok)
    );

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_logic (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_logic_supply_ok),
        .o_level(logic_ok)
    );

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_hot (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_temp_over_shutdown),
        .o_level(hot_shut)
    );

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_rec (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_temp_over_recovery),
        .o_level(hot_rec)
    );

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_short (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_short_detect),
        .o_level(short_s)
    );

    // Transmit idles high, so its synchroniser starts recessive and no false edge follows reset
    ictp_sync #(
        .RESET_VAL(1'b1)
    ) u_sync_txd (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_txd),
        .o_level(txd_s)
    );

    ictp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_bus (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_pin  (i_bus_dominant),
        .o_level(bus_dom)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ictp_pkg::ictp_mode_t mode;
        logic                 thermal;
        logic                 timeout;
        logic                 txd_prev;
        logic [CNT_W-1:0]     dom_cnt;
        logic                 drive;
        logic                 bias;
        logic                 climit;
        logic                 rxd;
        logic                 rxd_oe;
    } ictp_core_state_t;

    ictp_core_state_t state_reg;
    ictp_core_state_t state_next;

    logic supplies_ok;
    logic normal_next;
    logic drive_en;

    always_comb begin
        state_next  = state_reg;
        // A missing logic supply on the single-supply variant is not monitored
        supplies_ok = main_ok && (logic_ok || !HAS_LOGIC_SUPPLY);

        // ----------------------------------------------------------------
        // Mode
        // ----------------------------------------------------------------
        if (!supplies_ok) begin
            state_next.mode = ictp_pkg::ICTP_PROTECTED;
        end else begin
            state_next.mode = ictp_pkg::ICTP_NORMAL;
        end
        normal_next = (state_next.mode == ictp_pkg::ICTP_NORMAL);

        // ----------------------------------------------------------------
        // Thermal shutdown with hysteresis
        // ----------------------------------------------------------------
        if (hot_shut) begin
            state_next.thermal = 1'b1;
        end else if (!hot_rec) begin
            state_next.thermal = 1'b0;
        end

        // ----------------------------------------------------------------
        // Dominant timeout
        // ----------------------------------------------------------------
        state_next.txd_prev = txd_s;
        if (txd_s) begin
            state_next.dom_cnt = '0;
        end else if (state_reg.dom_cnt < CNT_W'(DTO_CYCLES)) begin
            state_next.dom_cnt = state_reg.dom_cnt + CNT_W'(1);
        end
        if (txd_s && !state_reg.txd_prev) begin
            state_next.timeout = 1'b0;
        end else if (!txd_s && state_reg.dom_cnt >= CNT_W'(DTO_CYCLES)) begin
            state_next.timeout = 1'b1;
        end
        if (!normal_next) begin
            state_next.timeout = 1'b0;
            state_next.dom_cnt = '0;
        end

        // ----------------------------------------------------------------
        // Outputs
        // ----------------------------------------------------------------
        drive_en = normal_next && !state_next.thermal && !state_next.timeout
                   && !txd_s;
        state_next.drive  = drive_en;
        // Bias to recessive whenever powered; released only when protected
        state_next.bias   = normal_next;
        // Limit tracks the short directly, so recovery needs no latch
        state_next.climit = drive_en && short_s;
        state_next.rxd_oe = normal_next;
        state_next.rxd    = normal_next ? !bus_dom : 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '{mode:     ictp_pkg::ICTP_PROTECTED,
                           thermal:  1'b0,
                           timeout:  1'b0,
                           txd_prev: 1'b1,
                           dom_cnt:  '0,
                           drive:    1'b0,
                           bias:     1'b0,
                           climit:   1'b0,
                           rxd:      1'b1,
                           rxd_oe:   1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_bus_drive_dominant = state_reg.drive;
    assign o_bus_bias_en        = state_reg.bias;
    assign o_current_limit      = state_reg.climit;
    assign o_rxd                = state_reg.rxd;
    assign o_rxd_oe             = state_reg.rxd_oe;
    assign o_status             = '{normal:  (state_reg.mode == ictp_pkg::ICTP_NORMAL),
                                    thermal: state_reg.thermal,
                                    timeout: state_reg.timeout};

endmodule

`default_nettype wire

// ---- core/ictp_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to i_clk.
`default_nettype none

module ictp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_pin,
    output var  logic o_level
);

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } ictp_sync_state_t;

    ictp_sync_state_t state_reg;
    ictp_sync_state_t state_next;

    always_comb begin
        state_next       = state_reg;
        state_next.stage = {state_reg.stage[1:0], i_pin};
        // Only stages two and three are compared; stage one feeds stage two alone
        if (state_reg.stage[1] == state_reg.stage[2]) begin
            state_next.level = state_reg.stage[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '{stage: {3{RESET_VAL}}, level: RESET_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_level = state_reg.level;

endmodule

`default_nettype wire

// ---- inc/ictp_pkg.sv ----
// Types for the isolated transceiver protection block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ictp_pkg;

    typedef enum logic [0:0] {
        ICTP_PROTECTED,
        ICTP_NORMAL
    } ictp_mode_t;

    // Status flags gathered as one carrier
    typedef struct packed {
        logic normal;
        logic thermal;
        logic timeout;
    } ictp_status_t;

endpackage

`default_nettype wire

// ---- inc/ictp_regs.svh ----
// Timing constants for the isolated transceiver protection block.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef ICTP_REGS_SVH
`define ICTP_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ICTP_CLK_HZ            20000000
`define ICTP_DTO_PERIOD_US     2000
// Longest dominant time rounds down to whole cycles
`define ICTP_DTO_CYCLES        ((`ICTP_DTO_PERIOD_US * (`ICTP_CLK_HZ / 1000000)))

`endif

// ---- sim/ictp_bus_model.sv ----
// Bus model: the wire reads dominant while the local driver or a remote node pulls it.
// Assumes the core's comparator pin is fed from this model.
`default_nettype none
module ictp_bus_model (
    input  wire logic i_drive_dominant,
    input  wire logic i_remote_dominant,
    output var  logic o_bus_dominant
);
    timeunit 1ns;
    timeprecision 1ns;
    // Remote nodes may claim the bus in any mode, so the receive path stays testable
    always_comb o_bus_dominant = i_drive_dominant | i_remote_dominant;
endmodule
`default_nettype wire

// ---- sim/ictp_core_props.sv ----
// Port checks for the transceiver protection core.
// Assumes one clock and the synchronous reset; bound into every core instance.
`default_nettype none

`include "ictp_regs.svh"

module ictp_core_props #(
    parameter int DTO_CYCLES = `ICTP_DTO_CYCLES
) (
    input wire logic                   i_clk,
    input wire logic                   i_reset,
    input wire logic                   i_txd,
    input wire logic                   i_bus_dominant,
    input wire logic                   i_temp_over_recovery,
    input wire logic                   o_bus_drive_dominant,
    input wire logic                   o_bus_bias_en,
    input wire logic                   o_current_limit,
    input wire logic                   o_rxd,
    input wire logic                   o_rxd_oe,
    input wire ictp_pkg::ictp_status_t o_status
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------
    // Helper: length of the current dominant drive run
    // -----------------------------------------------
    int drive_run;
    always_ff @(posedge i_clk) begin
        if (i_reset || !o_bus_drive_dominant) begin
            drive_run <= 0;
        end else begin
            drive_run <= drive_run + 1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_prot_release;
        !o_status.normal |-> !o_bus_bias_en && !o_rxd_oe && !o_bus_drive_dominant;
    endproperty
    a_prot_release: assert property (p_prot_release) else $error("protected outputs not released");
    property p_normal_up;
        o_status.normal |-> o_bus_bias_en && o_rxd_oe;
    endproperty
    a_normal_up: assert property (p_normal_up) else $error("normal mode outputs not enabled");
    property p_therm_off;
        o_status.thermal |-> !o_bus_drive_dominant;
    endproperty
    a_therm_off: assert property (p_therm_off) else $error("drive during thermal shutdown");
    property p_therm_clear;
        $fell(o_status.thermal) && o_status.normal |-> !$past(i_temp_over_recovery, 2)
            || !$past(i_temp_over_recovery, 4) || !$past(i_temp_over_recovery, 6);
    endproperty
    a_therm_clear: assert property (p_therm_clear) else $error("thermal cleared while hot");
    property p_dto_off;
        o_status.timeout |-> !o_bus_drive_dominant;
    endproperty
    a_dto_off: assert property (p_dto_off) else $error("drive during timeout fault");
    property p_dto_bound;
        drive_run <= DTO_CYCLES + 2;
    endproperty
    a_dto_bound: assert property (p_dto_bound) else $error("dominant run too long");
    property p_dto_release;
        $fell(o_status.timeout) && o_status.normal |-> $past(i_txd, 2) || $past(i_txd, 3)
            || $past(i_txd, 4) || $past(i_txd, 5) || $past(i_txd, 6);
    endproperty
    a_dto_release: assert property (p_dto_release) else $error("timeout cleared without edge");
    property p_climit;
        o_current_limit |-> o_bus_drive_dominant;
    endproperty
    a_climit: assert property (p_climit) else $error("current limit without drive");
    property p_rx_low;
        o_status.normal && !o_rxd |-> $past(i_bus_dominant, 2) || $past(i_bus_dominant, 3)
            || $past(i_bus_dominant, 4) || $past(i_bus_dominant, 5) || $past(i_bus_dominant, 6);
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("receive low on recessive bus");
endmodule
bind ictp_core ictp_core_props #(.DTO_CYCLES(DTO_CYCLES)) props_u (.i_clk(i_clk),
    .i_reset(i_reset), .i_txd(i_txd), .i_bus_dominant(i_bus_dominant),
    .i_temp_over_recovery(i_temp_over_recovery), .o_bus_drive_dominant(o_bus_drive_dominant),
    .o_bus_bias_en(o_bus_bias_en), .o_current_limit(o_current_limit), .o_rxd(o_rxd),
    .o_rxd_oe(o_rxd_oe), .o_status(o_status));
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the protection core and a small bus model.
// Assumes outputs settle within eight cycles of a pin change, twelve through the bus loop.
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %b got %b", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DTO = 20;
    logic clk = 1'b0, rst = 1'b1, mok = 1'b1, lok = 1'b1, tsd = 1'b0, trc = 1'b0;
    logic sht = 1'b0, txd = 1'b1, rem = 1'b0, bus, drv, bias, clim, rxd, rxoe;
    ictp_pkg::ictp_status_t st;
    int fails = 0, compares = 0;
    always #25 clk = ~clk;
    ictp_core #(.DTO_CYCLES(DTO)) dut_u (.i_clk(clk), .i_reset(rst), .i_main_supply_ok(mok),
        .i_logic_supply_ok(lok), .i_temp_over_shutdown(tsd), .i_temp_over_recovery(trc),
        .i_short_detect(sht), .i_txd(txd), .i_bus_dominant(bus), .o_bus_drive_dominant(drv),
        .o_bus_bias_en(bias), .o_current_limit(clim), .o_rxd(rxd), .o_rxd_oe(rxoe), .o_status(st));
    ictp_bus_model bus_u (.i_drive_dominant(drv), .i_remote_dominant(rem), .o_bus_dominant(bus));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic report_and_stop();
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wait_normal();
        int n;
        n = 0;
        while (st.normal !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (st.normal !== 1'b1) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic t_supply();
        wait_normal();
        `CHK("bias", 1'b1, bias)
        `CHK("rxd_oe", 1'b1, rxoe)
        mok = 1'b0;
        txd = 1'b0;
        cyc(8);
        `CHK("bias", 1'b0, bias)
        `CHK("rxd_oe", 1'b0, rxoe)
        `CHK("drive", 1'b0, drv)
        txd = 1'b1;
        mok = 1'b1;
        lok = 1'b0;
        cyc(8);
        `CHK("normal", 1'b0, st.normal)
        lok = 1'b1;
        wait_normal();
    endtask
    task automatic t_tx();
        // Dominant runs stay far inside the timeout
        // Receive trails transmit by two synchroniser passes, about ten cycles
        txd = 1'b0;
        cyc(12);
        `CHK("drive", 1'b1, drv)
        `CHK("rxd", 1'b0, rxd)
        txd = 1'b1;
        cyc(12);
        `CHK("drive", 1'b0, drv)
        `CHK("rxd", 1'b1, rxd)
    endtask
    task automatic t_thermal();
        tsd = 1'b1;
        trc = 1'b1;
        cyc(8);
        txd = 1'b0;
        cyc(8);
        `CHK("drive", 1'b0, drv)
        `CHK("bias", 1'b1, bias)
        txd = 1'b1;
        rem = 1'b1;
        cyc(8);
        `CHK("rxd", 1'b0, rxd)
        rem = 1'b0;
        tsd = 1'b0;
        cyc(8);
        `CHK("thermal", 1'b1, st.thermal)
        trc = 1'b0;
        txd = 1'b0;
        cyc(8);
        `CHK("drive", 1'b1, drv)
        txd = 1'b1;
        cyc(8);
    endtask
    task automatic t_short();
        txd = 1'b0;
        sht = 1'b1;
        cyc(8);
        `CHK("climit", 1'b1, clim)
        sht = 1'b0;
        cyc(8);
        `CHK("climit", 1'b0, clim)
        `CHK("drive", 1'b1, drv)
        txd = 1'b1;
        cyc(8);
    endtask
    task automatic t_timeout();
        txd = 1'b0;
        cyc(DTO);
        `CHK("drive", 1'b1, drv)
        cyc(10);
        `CHK("drive", 1'b0, drv)
        `CHK("timeout", 1'b1, st.timeout)
        txd = 1'b1;
        cyc(8);
        `CHK("timeout", 1'b0, st.timeout)
        txd = 1'b0;
        cyc(8);
        `CHK("drive", 1'b1, drv)
        txd = 1'b1;
        cyc(8);
    endtask
    initial begin
        cyc(4);
        rst = 1'b0;
        t_supply();
        t_tx();
        t_thermal();
        t_short();
        t_timeout();
        report_and_stop();
    end
endmodule
`default_nettype wire
